// [src/apc_readout.sv]
/*
  Pin control and readout for a four-channel simultaneous-sampling converter:
  conversion sequencing, power and reference controls, parallel, byte and
  serial readout. Assumes the analog core presents four 16-bit results on
  core_result by the end of the conversion time, and that all pins arrive
  asynchronously to clk.
*/
// Functional notes
// - reference select high enables internal band-gap; low powers it down; buffer stays on
// - reference select is asynchronous, follows the pin, comes up per pin
// - range high selects the wide span, low the narrow span, all channels
// - power-down input high is normal operation, low enters a low-power mode
// - power-down low with range one is standby, range zero is shutdown
// - shutdown powers everything down (internal_ref_en still follows reference select); standby keeps reference and regulators
// - interface select low is parallel; high picks serial or byte by byte select
// - first start holds channels one-two, second holds three-four
// - start rising edge puts track-and-hold into hold and converts
// - busy rises after both edges, blocks starts, falls once results latched
// - active-high reset clears all digital logic asynchronously while held
// - reset aborts a conversion and clears the output data registers
// - in parallel and byte modes the bus drives only with select and read low
// - in serial mode the shared pin is the serial clock, rising edge timed
// - select rising tri-states all outputs; select falling starts a frame
// - parallel mode uses sixteen data lines, byte mode eight
// - serial frame start enables both serial outputs showing the first MSB
// - three-bit oversampling code, MSB first, sets the filter ratio
module apc_readout
  import apc_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // device control pins
  input wire logic device_reset,
  input wire logic convert_start_first_half,
  input wire logic convert_start_second_half,
  input wire logic cs_n,
  input wire logic rd_sclk,
  input wire logic reference_select,
  input wire logic range_select,
  input wire logic power_down_n,
  input wire logic interface_select,
  input wire logic byte_mode_select,
  input wire logic [2:0] oversample_ratio_sel,
  // analog core results, channel 1 in the low word
  input wire logic [NCH*DW-1:0] core_result,
  // conversion status and front-end controls
  output logic busy,
  output logic hold_first_half,
  output logic hold_second_half,
  // power and reference controls
  output logic internal_ref_en,
  output logic bandgap_en,
  output logic ref_buffer_en,
  output logic regulators_en,
  output logic analog_en,
  output logic range_10v,
  output logic [7:0] osr_count,
  // parallel data bus
  output logic [15:0] parallel_data_bus_o,
  output logic [15:0] parallel_data_bus_oe,
  // serial data outputs
  output logic serial_out_first_half,
  output logic serial_out_first_half_oe,
  output logic serial_out_second_half,
  output logic serial_out_second_half_oe
);

  // ------------------------------------------------------------------
  // reset: asynchronous assert, synchronised release
  // ------------------------------------------------------------------
  logic arst_n;
  logic [1:0] rsync_q;
  logic core_rst_n;

  // either reset source clears the core at once
  assign arst_n = rst_b & ~device_reset;

  // release passes two flops so no flop leaves reset in a metastable cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rsync_q <= 2'b00;
    else
      rsync_q <= {rsync_q[0], 1'b1};
  end
  assign core_rst_n = rsync_q[1];

  // ------------------------------------------------------------------
  // state and result memory
  // ------------------------------------------------------------------
  apc_state_t q;
  apc_state_t d;
  logic [NPIN-1:0] pins_in;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic [DW-1:0] rdata_a;
  logic [DW-1:0] rdata_b;
  apc_mode_t mode;
  logic cs_low;
  logic rd_low;
  logic start_done;

  assign pins_in = {oversample_ratio_sel, byte_mode_select, interface_select, power_down_n,
    range_select, reference_select, rd_sclk, cs_n, convert_start_second_half,
    convert_start_first_half};

  apc_result_mem #(
    .WIDTH(DW),
    .DEPTH(NCH),
    .AW(2)
  ) u_mem (
    .clk(clk),
    .rst_n(core_rst_n),
    .we(q.we),
    .wdata(core_result),
    .raddr_a(q.ch),
    .raddr_b(q.ch + SER_PAIR_OFS),
    .rdata_a(rdata_a),
    .rdata_b(rdata_b)
  );

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    d = q;
    // three stages; a level counts once stages two and three agree
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pin = (q.s2 & q.s3) | (q.pin & (q.s2 ^ q.s3));
    rise = d.pin & ~q.pin;
    fall = q.pin & ~d.pin;
    mode = apc_mode(q.pin[PIN_IF_SEL], q.pin[PIN_BYTE_SEL]);
    cs_low = ~q.pin[PIN_CS_N];
    rd_low = ~q.pin[PIN_RD_SCLK];
    start_done = 1'b0;

    // power and reference: follow the pins, no latching
    d.ana = q.pin[PIN_PD_N];
    d.regs = q.pin[PIN_PD_N] | q.pin[PIN_RANGE];
    d.rbuf = q.pin[PIN_PD_N] | q.pin[PIN_RANGE];
    d.iref = q.pin[PIN_REF_SEL];
    d.bg = q.pin[PIN_REF_SEL] & (q.pin[PIN_PD_N] | q.pin[PIN_RANGE]);
    d.r10 = q.pin[PIN_RANGE];
    d.osr = apc_osr_count(q.pin[PIN_OS_LO +: 3]);

    // conversion sequencing
    d.we = 1'b0;
    unique case (q.conv)
      APC_IDLE, APC_ARMED:
      begin
        if (!q.pin[PIN_PD_N])
        begin
          d.conv = APC_IDLE;
          d.seen_a = 1'b0;
          d.seen_b = 1'b0;
          d.hold_a = 1'b0;
          d.hold_b = 1'b0;
        end
        else
        begin
          if (rise[PIN_CONV_A])
          begin
            d.seen_a = 1'b1;
            d.hold_a = 1'b1;
          end
          if (rise[PIN_CONV_B])
          begin
            d.seen_b = 1'b1;
            d.hold_b = 1'b1;
          end
          start_done = d.seen_a & d.seen_b;
          if (start_done)
          begin
            d.conv = APC_CONV;
            d.busy = 1'b1;
            d.cnt = 24'(CONV_CYC * int'(d.osr)) - 24'h000001;
          end
          else if (d.seen_a | d.seen_b)
            d.conv = APC_ARMED;
        end
      end
      APC_CONV:
      begin
        // start pins are not looked at here, so edges during busy are lost
        if (!q.pin[PIN_PD_N])
        begin
          d.conv = APC_IDLE; // power-down abandons the conversion
          d.busy = 1'b0;
          d.hold_a = 1'b0;
          d.hold_b = 1'b0;
          d.seen_a = 1'b0;
          d.seen_b = 1'b0;
        end
        else if (q.cnt == 24'h000000)
        begin
          d.conv = APC_LATCH;
          d.we = 1'b1;
        end
        else
          d.cnt = q.cnt - 24'h000001;
      end
      APC_LATCH:
      begin
        // results are written to the output registers at the edge that leaves this state; front ends track again
        d.conv = APC_IDLE;
        d.busy = 1'b0;
        d.hold_a = 1'b0;
        d.hold_b = 1'b0;
        d.seen_a = 1'b0;
        d.seen_b = 1'b0;
      end
    endcase

    // readout position: a falling select starts every frame at channel 1
    if (fall[PIN_CS_N])
    begin
      d.ch = 2'h0;
      d.bitn = 4'h0;
      d.byte_hi = 1'b1;
    end
    else if (cs_low && rise[PIN_RD_SCLK])
    begin
      unique case (mode)
        APC_MODE_PAR:
          d.ch = q.ch + 2'h1;
        APC_MODE_BYTE:
        begin
          // high byte first, then low byte, then next channel
          d.byte_hi = ~q.byte_hi;
          if (!q.byte_hi)
            d.ch = q.ch + 2'h1;
        end
        APC_MODE_SER:
        begin
          // serial clock rising edge moves to the next bit
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == SER_LAST_BIT)
            d.ch = q.ch + 2'h1;
        end
      endcase
    end

    // parallel bus: drives only while select and read are both low
    d.par_o = rdata_a;
    d.par_oe = 16'h0000;
    if (mode == APC_MODE_BYTE)
      d.par_o = {8'h00, q.byte_hi ? rdata_a[15:8] : rdata_a[7:0]};
    if (cs_low && rd_low && mode == APC_MODE_PAR)
      d.par_oe = OE_WORD;
    else if (cs_low && rd_low && mode == APC_MODE_BYTE)
      d.par_oe = OE_BYTE;

    // serial outputs: bit 15 first; inverting the bit count picks 15 down to 0
    d.sa = rdata_a[~q.bitn];
    d.sb = rdata_b[~q.bitn];
    d.sa_oe = cs_low && mode == APC_MODE_SER;
    d.sb_oe = cs_low && mode == APC_MODE_SER;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      q <= '0; // aborts any conversion in flight
      q.pin <= PIN_RST;
      q.s1 <= PIN_RST;
      q.s2 <= PIN_RST;
      q.s3 <= PIN_RST;
    end
    else
      q <= d;
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------------
  assign busy = q.busy;
  assign hold_first_half = q.hold_a;
  assign hold_second_half = q.hold_b;
  assign internal_ref_en = q.iref;
  assign bandgap_en = q.bg;
  assign ref_buffer_en = q.rbuf;
  assign regulators_en = q.regs;
  assign analog_en = q.ana;
  assign range_10v = q.r10;
  assign osr_count = q.osr;
  assign parallel_data_bus_o = q.par_o;
  assign parallel_data_bus_oe = q.par_oe;
  assign serial_out_first_half = q.sa;
  assign serial_out_first_half_oe = q.sa_oe;
  assign serial_out_second_half = q.sb;
  assign serial_out_second_half_oe = q.sb_oe;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!core_rst_n);
  sequence start_a_seq;
    (q.conv == APC_IDLE || q.conv == APC_ARMED) && q.pin[PIN_PD_N] && rise[PIN_CONV_A];
  endsequence

  sequence conv_end_seq;
    q.conv == APC_CONV && q.cnt == 24'h000000 && q.pin[PIN_PD_N];
  endsequence

  hold_first_a: assert property (start_a_seq |=> q.hold_a)
    else $error("first-half start edge did not hold channels 1-2");
  busy_end_a: assert property (conv_end_seq |=> q.we && q.busy ##1 !q.busy && !q.we)
    else $error("busy did not fall right after the results were latched");
  busy_conv_a: assert property ((q.conv == APC_CONV) |-> q.busy && q.hold_a && q.hold_b)
    else $error("conversion running without busy and both holds");
  shutdown_pwr_a: assert property (!q.pin[PIN_PD_N] && !q.pin[PIN_RANGE]
    |=> !q.rbuf && !q.regs && !q.bg && !q.ana)
    else $error("shutdown left circuitry powered");
  standby_pwr_a: assert property (!q.pin[PIN_PD_N] && q.pin[PIN_RANGE]
    |=> q.rbuf && q.regs && !q.ana)
    else $error("standby did not keep reference and regulators");
  ref_follow_a: assert property (q.pin[PIN_PD_N] |=> q.bg == $past(q.pin[PIN_REF_SEL]))
    else $error("band-gap enable does not follow reference select");
  range_follow_a: assert property (##1 q.r10 == $past(q.pin[PIN_RANGE]))
    else $error("range output does not follow the range pin");
  bus_enable_a: assert property ((q.par_oe != 16'h0000)
    |-> $past(!q.pin[PIN_CS_N] && !q.pin[PIN_RD_SCLK] && mode != APC_MODE_SER))
    else $error("parallel bus driven without select and read low");
  cs_tristate_a: assert property ($rose(q.pin[PIN_CS_N])
    |=> q.par_oe == 16'h0000 && !q.sa_oe && !q.sb_oe)
    else $error("outputs still driven after select went high");
  byte_lanes_a: assert property ((mode == APC_MODE_BYTE) |=> q.par_oe[15:8] == 8'h00)
    else $error("byte mode drove the upper lanes");
  frame_start_a: assert property ($fell(q.pin[PIN_CS_N]) && mode == APC_MODE_SER
    |=> q.ch == 2'h0 && q.bitn == 4'h0 ##2 q.sa_oe && q.sa == rdata_a[15])
    else $error("serial frame did not start at the first MSB");
  // the edge that releases reset still loads reset values, so start one edge later
  osr_decode_a: assert property (core_rst_n
    |=> q.osr == apc_osr_count($past(q.pin[PIN_OS_LO +: 3])))
    else $error("oversampling count mismatch");

endmodule : apc_readout

// [src/apc_pkg.sv]
/*
  Package for the converter pin control and readout block: pin indices,
  conversion timing, state encodings, the state record and decode helpers.
  Assumes a 100 MHz core clock and four 16-bit channels.
*/
package apc_pkg;

  // ------------------------------------------------------------------
  // pin vector layout (after the three-stage synchroniser)
  // ------------------------------------------------------------------
  localparam int NPIN = 12;
  localparam int PIN_CONV_A = 0;
  localparam int PIN_CONV_B = 1;
  localparam int PIN_CS_N = 2;
  localparam int PIN_RD_SCLK = 3;
  localparam int PIN_REF_SEL = 4;
  localparam int PIN_RANGE = 5;
  localparam int PIN_PD_N = 6;
  localparam int PIN_IF_SEL = 7;
  localparam int PIN_BYTE_SEL = 8;
  localparam int PIN_OS_LO = 9;
  // chip select and read strobe idle high, everything else low
  localparam logic [NPIN-1:0] PIN_RST = 12'h00C;

  // ------------------------------------------------------------------
  // data shape and timing
  // ------------------------------------------------------------------
  localparam int NCH = 4;
  localparam int DW = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SER_LAST_BIT = 4'hF;
  localparam logic [1:0] SER_PAIR_OFS = 2'h2;
  localparam logic [15:0] OE_WORD = 16'hFFFF;
  localparam logic [15:0] OE_BYTE = 16'h00FF;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    APC_IDLE = 2'b00,
    APC_ARMED = 2'b01,
    APC_CONV = 2'b11,
    APC_LATCH = 2'b10
  } apc_conv_t;

  typedef enum logic [1:0] {
    APC_MODE_PAR = 2'b00,
    APC_MODE_SER = 2'b01,
    APC_MODE_BYTE = 2'b11
  } apc_mode_t;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] pin;
    apc_conv_t conv;
    logic seen_a;
    logic seen_b;
    logic [23:0] cnt;
    logic we;
    logic busy;
    logic hold_a;
    logic hold_b;
    logic [1:0] ch;
    logic [3:0] bitn;
    logic byte_hi;
    logic [15:0] par_o;
    logic [15:0] par_oe;
    logic sa;
    logic sa_oe;
    logic sb;
    logic sb_oe;
    logic iref;
    logic bg;
    logic rbuf;
    logic regs;
    logic ana;
    logic r10;
    logic [7:0] osr;
  } apc_state_t;

  // interface mode from the two select pins
  function automatic apc_mode_t apc_mode(input logic if_sel, input logic byte_sel);
    if (!if_sel)
      return APC_MODE_PAR;
    return byte_sel ? APC_MODE_BYTE : APC_MODE_SER;
  endfunction : apc_mode

  // averaging count per result; code 7 is not a ratio and falls back to one
  function automatic logic [7:0] apc_osr_count(input logic [2:0] os);
    if (os == 3'h7)
      return 8'h01;
    return 8'h01 << os;
  endfunction : apc_osr_count

endpackage : apc_pkg

// [src/apc_result_mem.sv]
/*
  Output data registers: one word per channel, written all at once when a
  conversion completes, two registered read ports for the readout logic.
  Assumes the reset input already has a synchronous release.
*/
module apc_result_mem
  import apc_pkg::*;
#(
  parameter int WIDTH = DW,
  parameter int DEPTH = NCH,
  parameter int AW = 2
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic we,
  input wire logic [DEPTH*WIDTH-1:0] wdata,
  // read side
  input wire logic [AW-1:0] raddr_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_a,
  output logic [WIDTH-1:0] rdata_b
);

  logic [DEPTH-1:0][WIDTH-1:0] mem_q;

  // reset clears every word, so a reset during a read shows zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_q <= '0;
      rdata_a <= '0;
      rdata_b <= '0;
    end
    else
    begin
      if (we)
        mem_q <= wdata;
      rdata_a <= mem_q[raddr_a];
      rdata_b <= mem_q[raddr_b];
    end
  end

endmodule : apc_result_mem

// [tb/apc_host_model.sv]
/*
  Host reader model: owns chip select and the shared strobe/serial-clock pin.
  Offers tasks for parallel, byte and serial frames. Assumes a 100 MHz bench clock.
*/
module apc_host_model
(
  // clock
  input wire logic clk,
  // readout controls
  output logic cs_n,
  output logic rd_sclk,
  // data returned by the device
  input wire logic [15:0] parallel_data_bus_o,
  input wire logic [15:0] parallel_data_bus_oe,
  input wire logic serial_out_first_half,
  input wire logic serial_out_first_half_oe,
  input wire logic serial_out_second_half,
  input wire logic serial_out_second_half_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 8; // half of the 160 ns serial clock

  // parked deselected; the serial clock stands still high between frames
  initial
  begin
    cs_n = 1'b1;
    rd_sclk = 1'b1;
  end

  // let n edges pass, then step past the register updates
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic open_frame();
    @(posedge clk) cs_n <= 1'b0;
    wait_clk(HALF);
  endtask : open_frame

  // deselect and report whether every data output let go
  task automatic close_frame(output logic released);
    @(posedge clk) cs_n <= 1'b1;
    wait_clk(HALF);
    released = (parallel_data_bus_oe === 16'h0000) && (serial_out_first_half_oe === 1'b0)
      && (serial_out_second_half_oe === 1'b0);
  endtask : close_frame

  // one read strobe; lines not driven read as zero
  task automatic par_strobe(output logic [15:0] d, output logic [15:0] oe,
    output logic [15:0] oe_after);
    @(posedge clk) rd_sclk <= 1'b0;
    wait_clk(HALF);
    d = parallel_data_bus_o & parallel_data_bus_oe;
    oe = parallel_data_bus_oe;
    @(posedge clk) rd_sclk <= 1'b1;
    wait_clk(HALF);
    oe_after = parallel_data_bus_oe;
  endtask : par_strobe

  // 32 serial clocks; bits are taken on the falling clock, so a change
  // after the rising edge has half a period to settle
  task automatic ser_frame(output logic [31:0] a, output logic [31:0] b,
    output logic [1:0] oe);
    open_frame();
    oe = {serial_out_first_half_oe, serial_out_second_half_oe};
    a = 32'h0000_0000;
    b = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk) rd_sclk <= 1'b0;
      #1;
      a = {a[30:0], serial_out_first_half};
      b = {b[30:0], serial_out_second_half};
      wait_clk(HALF - 1);
      @(posedge clk) rd_sclk <= 1'b1;
      wait_clk(HALF - 1);
    end
  endtask : ser_frame
endmodule : apc_host_model

// [tb/tb.sv]
/*
  Self-checking bench for the converter pin control and readout block.
  Assumes a shortened conversion count and two alternating analog result patterns.
*/
module tb
  import apc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CONV = 4;
  localparam logic [63:0] DATA = 64'h8C41_73B2_5E0D_A196;
  logic clk, rst_b, dev_rst, conv_a, conv_b, cs_n, rd_sclk;
  logic ref_sel, range_sel, pd_n, if_sel, byte_sel;
  logic [2:0] os_sel;
  logic [63:0] core_data;
  logic busy, hold_a, hold_b, iref, bg, rbuf, regs, ana, r10;
  logic [7:0] osr;
  logic [15:0] bus_o, bus_oe;
  logic sa, sa_oe, sb, sb_oe;
  int n_errors = 0;
  int tests_run = 0;

  apc_readout #(.CONV_CYC(CONV)) u_dut (
    .clk(clk), .rst_b(rst_b), .device_reset(dev_rst),
    .convert_start_first_half(conv_a), .convert_start_second_half(conv_b),
    .cs_n(cs_n), .rd_sclk(rd_sclk), .reference_select(ref_sel),
    .range_select(range_sel), .power_down_n(pd_n), .interface_select(if_sel),
    .byte_mode_select(byte_sel), .oversample_ratio_sel(os_sel), .core_result(core_data),
    .busy(busy), .hold_first_half(hold_a), .hold_second_half(hold_b),
    .internal_ref_en(iref), .bandgap_en(bg), .ref_buffer_en(rbuf),
    .regulators_en(regs), .analog_en(ana), .range_10v(r10), .osr_count(osr),
    .parallel_data_bus_o(bus_o), .parallel_data_bus_oe(bus_oe),
    .serial_out_first_half(sa), .serial_out_first_half_oe(sa_oe),
    .serial_out_second_half(sb), .serial_out_second_half_oe(sb_oe)
  );

  apc_host_model u_host (
    .clk(clk), .cs_n(cs_n), .rd_sclk(rd_sclk),
    .parallel_data_bus_o(bus_o), .parallel_data_bus_oe(bus_oe),
    .serial_out_first_half(sa), .serial_out_first_half_oe(sa_oe),
    .serial_out_second_half(sb), .serial_out_second_half_oe(sb_oe)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // mode pins only move while deselected
  task automatic set_mode(input logic i, input logic b);
    @(posedge clk)
    begin
      if_sel <= i;
      byte_sel <= b;
    end
    u_host.wait_clk(8);
  endtask : set_mode

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // every power, reference and range combination, standby and shutdown included
  task automatic config_pins();
    logic shut;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk)
      begin
        ref_sel <= k[0];
        range_sel <= k[1];
        pd_n <= k[2];
      end
      u_host.wait_clk(8);
      shut = !k[2] && !k[1];
      chk(iref, k[0]);
      chk(bg, k[0] && !shut);
      chk(rbuf, !shut);
      chk(regs, !shut);
      chk(ana, k[2]);
      chk(r10, k[1]);
    end
    // the sweep passed through shutdown: pulse reset, then let the range settle
    @(posedge clk) dev_rst <= 1'b1;
    @(posedge clk) dev_rst <= 1'b0;
    u_host.wait_clk(8000);
  endtask : config_pins

  task automatic osr_codes();
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clk) os_sel <= 3'(c);
      u_host.wait_clk(8);
      chk(osr, 8'(c == 7 ? 1 : (1 << c)));
    end
  endtask : osr_codes

  // split mode shows the first half holding alone; otherwise both starts move together
  task automatic convert(input logic [2:0] os, input bit split, input logic [63:0] res);
    int n;
    @(posedge clk)
    begin
      os_sel <= os;
      core_data <= res;
    end
    u_host.wait_clk(8);
    @(posedge clk)
    begin
      conv_a <= 1'b1;
      conv_b <= !split;
    end
    if (split)
    begin
      u_host.wait_clk(8);
      chk({hold_a, hold_b, busy}, 3'b100);
      @(posedge clk) conv_b <= 1'b1;
    end
    n = 0;
    do
    begin
      u_host.wait_clk(1);
      n++;
    end
    while (busy !== 1'b1 && n < 20);
    chk(n <= 6, 1'b1);
    chk({hold_a, hold_b}, 2'b11);
    n = 0;
    while (busy === 1'b1 && n < 2000)
    begin
      n++;
      u_host.wait_clk(1);
    end
    chk(n, CONV * (os == 3'h7 ? 1 : (1 << os)) + 1);
    chk({hold_a, hold_b}, 2'b00);
    @(posedge clk)
    begin
      conv_a <= 1'b0;
      conv_b <= 1'b0;
    end
    u_host.wait_clk(8);
  endtask : convert

  // five words (ten bytes) so the channel count wraps back to the first
  task automatic par_read(input bit byte_mode, input logic [63:0] exp);
    logic [15:0] d, oe, oe_after, w;
    logic rel;
    set_mode(byte_mode, byte_mode);
    u_host.open_frame();
    for (int j = 0; j < (byte_mode ? 10 : 5); j++)
    begin
      w = exp[16 * ((byte_mode ? j / 2 : j) % 4) +: 16];
      u_host.par_strobe(d, oe, oe_after);
      chk(d, byte_mode ? (j % 2 == 0 ? w[15:8] : w[7:0]) : w);
      chk(oe, byte_mode ? OE_BYTE : OE_WORD);
      chk(oe_after, 16'h0000);
    end
    u_host.close_frame(rel);
    chk(rel, 1'b1);
  endtask : par_read

  task automatic ser_read(input logic [63:0] exp);
    logic [31:0] a, b;
    logic [1:0] oe;
    logic rel;
    set_mode(1'b1, 1'b0);
    u_host.ser_frame(a, b, oe);
    chk(oe, 2'b11);
    chk(a, {exp[15:0], exp[31:16]});
    chk(b, {exp[47:32], exp[63:48]});
    u_host.close_frame(rel);
    chk(rel, 1'b1);
  endtask : ser_read

  // power-down (pd) or device reset (rst) lands mid-conversion
  task automatic abort_conv(input bit by_reset);
    // a fresh pattern on the core shows whether an aborted conversion wrote anything
    @(posedge clk)
    begin
      os_sel <= 3'h3;
      core_data <= DATA;
    end
    u_host.wait_clk(8);
    @(posedge clk)
    begin
      conv_a <= 1'b1;
      conv_b <= 1'b1;
    end
    u_host.wait_clk(8);
    @(posedge clk)
    begin
      dev_rst <= by_reset;
      pd_n <= by_reset;
    end
    u_host.wait_clk(8);
    chk({busy, hold_a, hold_b, bus_oe}, 19'h0);
    @(posedge clk)
    begin
      dev_rst <= 1'b0;
      pd_n <= 1'b1;
      conv_a <= 1'b0;
      conv_b <= 1'b0;
    end
    u_host.wait_clk(100);
  endtask : abort_conv

  // ------------------------------------------------------------------
  // clock, main sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {rst_b, dev_rst, conv_a, conv_b, if_sel, byte_sel} = 6'h00;
    {ref_sel, range_sel, pd_n} = 3'h7;
    os_sel = 3'h0;
    core_data = DATA;
    u_host.wait_clk(2);
    chk({busy, bus_oe, sa_oe, sb_oe}, 19'h0);
    repeat (18) @(posedge clk);
    rst_b <= 1'b1;
    u_host.wait_clk(10);
    chk(iref, 1'b1);
    config_pins();
    osr_codes();
    convert(3'h0, 1'b1, DATA);
    par_read(1'b0, DATA);
    par_read(1'b1, DATA);
    ser_read(DATA);
    convert(3'h3, 1'b0, ~DATA);
    ser_read(~DATA);
    abort_conv(1'b0);
    par_read(1'b0, ~DATA);
    abort_conv(1'b1);
    par_read(1'b0, 64'h0);
    end_of_test();
  end

  // the run needs about 10,000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : tb
